// [rtl/eec_pkg.sv]
// eec_pkg: shared constants, types and helpers for the eeprom host controller
package eec_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS           = 20;
    localparam int unsigned ADDR_ACCESS_DELAY_NS    = 450;
    localparam int unsigned WE_PULSE_NS             = 150;
    localparam int unsigned WR_RECOVERY_US          = 500;
    localparam int unsigned ERASE_HOLD_MS           = 10;
    localparam int unsigned NS_PER_US               = 1000;
    localparam int unsigned NS_PER_MS               = 1000000;
    localparam int unsigned SYNC_STAGES             = 3;

    // ==========================================================
    // widths and pin values
    localparam int unsigned ADDR_W                  = 13;
    localparam int unsigned DATA_W                  = 8;
    localparam int unsigned CNT_W                   = 20;
    localparam int unsigned POLL_BIT                = 7;
    localparam logic [7:0]  ERASE_DATA              = 8'hff;
    localparam logic [19:0] CNT_ZERO                = 20'h00000;
    localparam logic [19:0] CNT_ONE                 = 20'h00001;
    localparam logic [19:0] CNT_MAX                 = 20'hfffff;

    // ==========================================================
    // commands and states
    typedef enum logic [1:0] {
        EEC_CMD_READ,
        EEC_CMD_WRITE,
        EEC_CMD_ERASE,
        EEC_CMD_CLEAR
    } eec_cmd_e;

    typedef enum logic [3:0] {
        EEC_ST_IDLE,
        EEC_ST_READ,
        EEC_ST_WR_SETUP,
        EEC_ST_WR_PULSE,
        EEC_ST_WR_GAP,
        EEC_ST_POLL,
        EEC_ST_WR_REC,
        EEC_ST_ERASE,
        EEC_ST_CLEAR
    } eec_state_e;

    // ==========================================================
    // least time in ns to whole cycles, rounded up, never below one
    function automatic logic [19:0] ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c == 0) begin
            c = 1;
        end
        return c[19:0];
    endfunction

    localparam logic [19:0] ACC_CYC = ns_to_cyc(ADDR_ACCESS_DELAY_NS);
    localparam logic [19:0] WE_CYC  = ns_to_cyc(WE_PULSE_NS);
    localparam logic [19:0] SYNC_CYC = 20'(SYNC_STAGES);

endpackage

// [rtl/eec_sync_if.sv]
// eec_sync_if: raw pin inputs and their synchronised values
`timescale 1ns/1ps
`default_nettype none
interface eec_sync_if;
    logic [8:0] raw;
    logic [8:0] sync;
    modport sampler (input raw, output sync);
    modport user    (output raw, input sync);
endinterface
`default_nettype wire

// [rtl/eec_pin_sync.sv]
// eec_pin_sync: three-stage input sampler, takes a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module eec_pin_sync
    import eec_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    eec_sync_if.sampler     sif
);
    // ==========================================================
    // sampler chain
    // stage one feeds only stage two; metastability stays there
    logic [8:0] s1_q;
    logic [8:0] s2_q;
    logic [8:0] s3_q;
    logic [8:0] val_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 9'h000;
            s2_q <= 9'h000;
            s3_q <= 9'h000;
        end else begin
            s1_q <= sif.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            val_q <= 9'h000;
        end else begin
            for (int i = 0; i < 9; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    val_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign sif.sync = val_q;

endmodule // eec_pin_sync
`default_nettype wire

// [rtl/eec_host.sv]
// eec_host: host controller driving the strobes of a byte-wide eeprom
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module eec_host
    import eec_pkg::*;
#(
    parameter logic [19:0] WR_RECOVERY_CYC =
        ns_to_cyc(WR_RECOVERY_US * NS_PER_US),
    parameter logic [19:0] ERASE_CYC       =
        ns_to_cyc(ERASE_HOLD_MS * NS_PER_MS),
    parameter bit          USE_RDY_PIN     = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              req,
    input  wire logic [1:0]        cmd,
    input  wire logic [12:0]       addr,
    input  wire logic [7:0]        wdata,
    output logic                   ready,
    output logic                   done,
    output logic [7:0]             rdata,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic                   oe_hv,
    output logic                   we_hv,
    output logic [12:0]            mem_addr,
    output logic [7:0]             dq_o,
    output logic                   dq_oe,
    input  wire logic [7:0]        dq_i,
    input  wire logic              rdy_busy_i
);
    // ==========================================================
    // pin sampling
    eec_sync_if sif ();
    assign sif.raw = {rdy_busy_i, dq_i};

    eec_pin_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .sif  (sif.sampler)
    );

    logic [7:0] dq_s;
    logic       rdy_s;
    assign dq_s  = sif.sync[7:0];
    assign rdy_s = sif.sync[8];

    // ==========================================================
    // sequencer
    eec_state_e  state_q;
    eec_state_e  state_d;
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    logic [19:0] limit;
    logic        hit;
    logic [7:0]  wdata_q;
    logic [12:0] addr_q;
    logic        poll_ok;

    // sampled bus lags the pins by the sampler depth
    assign hit   = (cnt_q == limit - CNT_ONE);
    assign ready = (state_q == EEC_ST_IDLE);
    // without USE_RDY_PIN only bit seven decides completion, the rest are undefined; with it the synchronised rdy_busy_i pin decides
    assign poll_ok = USE_RDY_PIN ? rdy_s
                   : (dq_s[POLL_BIT] == wdata_q[POLL_BIT]);

    always_comb begin
        case (state_q)
            // the agreement register adds one cycle behind the three stages
            EEC_ST_READ, EEC_ST_POLL: limit = ACC_CYC + SYNC_CYC + CNT_ONE;
            EEC_ST_WR_PULSE:          limit = WE_CYC;
            EEC_ST_WR_GAP:            limit = ACC_CYC;
            EEC_ST_WR_REC:            limit = WR_RECOVERY_CYC;
            EEC_ST_ERASE, EEC_ST_CLEAR: limit = ERASE_CYC;
            default:                  limit = CNT_ONE;
        endcase
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = hit ? CNT_ZERO : cnt_q + CNT_ONE;
        case (state_q)
            EEC_ST_IDLE: begin
                cnt_d = CNT_ZERO;
                if (req) begin
                    case (eec_cmd_e'(cmd))
                        EEC_CMD_READ:  state_d = EEC_ST_READ;
                        EEC_CMD_WRITE: state_d = EEC_ST_WR_SETUP;
                        EEC_CMD_ERASE: state_d = EEC_ST_ERASE;
                        EEC_CMD_CLEAR: state_d = EEC_ST_CLEAR;
                        default:       state_d = EEC_ST_IDLE;
                    endcase
                end
            end
            EEC_ST_READ:     if (hit) state_d = EEC_ST_IDLE;
            EEC_ST_WR_SETUP: state_d = EEC_ST_WR_PULSE;
            EEC_ST_WR_PULSE: if (hit) state_d = EEC_ST_WR_GAP;
            EEC_ST_WR_GAP:   if (hit) state_d = EEC_ST_POLL;
            EEC_ST_POLL:     if (hit && poll_ok) state_d = EEC_ST_WR_REC;
            EEC_ST_WR_REC:   if (hit) state_d = EEC_ST_IDLE;
            EEC_ST_ERASE:    if (hit) state_d = EEC_ST_IDLE;
            EEC_ST_CLEAR:    if (hit) state_d = EEC_ST_IDLE;
            default:         state_d = EEC_ST_IDLE;
        endcase
    end

    // new requests are held off until the write and its recovery end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= EEC_ST_IDLE;
            cnt_q   <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_q  <= 13'h0000;
            wdata_q <= 8'h00;
        end else if (ready && req) begin
            addr_q  <= addr;
            wdata_q <= wdata;
        end
    end

    // ==========================================================
    // pin drive, strobes registered from the next state, address loaded while the current state is idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ce_n  <= 1'b1;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_hv <= 1'b0;
            we_hv <= 1'b0;
            dq_o  <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            ce_n  <= 1'b0;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_hv <= 1'b0;
            we_hv <= 1'b0;
            dq_o  <= wdata_q;
            dq_oe <= 1'b0;
            case (state_d)
                EEC_ST_READ, EEC_ST_POLL: begin
                    oe_n <= 1'b0;
                end
                EEC_ST_WR_SETUP: begin
                    dq_oe <= 1'b1;
                end
                EEC_ST_WR_PULSE: begin
                    we_n  <= 1'b0;
                    dq_oe <= 1'b1;
                end
                EEC_ST_ERASE: begin
                    oe_hv <= 1'b1;
                    dq_o  <= ERASE_DATA;
                    dq_oe <= 1'b1;
                end
                EEC_ST_CLEAR: begin
                    oe_hv <= 1'b1;
                    we_hv <= 1'b1;
                end
                EEC_ST_WR_GAP: begin
                    ce_n <= 1'b0;
                end
                default: begin
                    ce_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= 13'h0000;
        end else if (state_q == EEC_ST_IDLE) begin
            mem_addr <= addr;
        end
    end

    // ==========================================================
    // answers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done  <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= (state_q != EEC_ST_IDLE) && (state_d == EEC_ST_IDLE);
            if (state_q == EEC_ST_READ && hit) begin
                rdata <= dq_s;
            end
        end
    end

    // ==========================================================
    // checks
    logic [19:0] gap_q;
    logic [19:0] since_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_q   <= CNT_ZERO;
            since_q <= CNT_MAX;
        end else begin
            gap_q <= (state_q == EEC_ST_WR_PULSE) ? CNT_ZERO
                   : (gap_q == CNT_MAX) ? gap_q : gap_q + CNT_ONE;
            if (state_q == EEC_ST_POLL && state_d == EEC_ST_WR_REC) begin
                since_q <= CNT_ZERO;
            end else if (since_q != CNT_MAX) begin
                since_q <= since_q + CNT_ONE;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    write_strobe_a: assert property (
        state_q == EEC_ST_WR_PULSE |->
        !ce_n && !we_n && oe_n && dq_oe && dq_o == wdata_q)
        else $error("write strobes wrong");
    erase_levels_a: assert property (
        state_q == EEC_ST_ERASE |->
        !ce_n && we_n && oe_hv && !we_hv && dq_oe && dq_o == ERASE_DATA)
        else $error("erase levels wrong");
    clear_float_a: assert property (
        state_q == EEC_ST_CLEAR |-> !ce_n && oe_hv && we_hv && !dq_oe)
        else $error("clear levels wrong");
    poll_gap_a: assert property (
        $fell(oe_n) && state_q == EEC_ST_POLL |-> gap_q >= ACC_CYC)
        else $error("poll read too soon after write");
    poll_bit_a: assert property (
        state_q == EEC_ST_POLL && hit && poll_ok |=>
        state_q == EEC_ST_WR_REC ##1 ce_n)
        else $error("poll match not taken");
    write_spacing_a: assert property (
        $fell(we_n) |-> since_q >= WR_RECOVERY_CYC)
        else $error("write too soon after completion");
    standby_idle_a: assert property (
        state_q == EEC_ST_IDLE |-> ce_n && !dq_oe && !oe_hv && !we_hv)
        else $error("standby pins wrong");
    read_inhibit_a: assert property (
        !oe_n |-> we_n && !dq_oe && !oe_hv)
        else $error("write strobe during read");
    busy_hold_a: assert property (
        state_q == EEC_ST_WR_PULSE |-> !ready [*2])
        else $error("request taken during write");

    write_seen_c:  cover property (state_q == EEC_ST_WR_REC && hit);
    read_seen_c:   cover property (state_q == EEC_ST_READ && hit);
    repoll_seen_c: cover property (state_q == EEC_ST_POLL && hit && !poll_ok);

endmodule // eec_host
`default_nettype wire

// [testbench/eec_mem_model.sv]
// eec_mem_model: behavioural byte-wide eeprom seen from its pins
`timescale 1ns/1ps
`default_nettype none
module eec_mem_model #(
    parameter int WR_NS = 3000
) (
    input  wire logic        clk,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        oe_hv,
    input  wire logic        we_hv,
    input  wire logic [12:0] addr,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    output logic      [7:0]  dq_i,
    output logic             rdy_busy
);
    // ==========================================================
    // array, internal write timer
    logic [7:0]  mem [8192];
    logic [7:0]  last_d;
    logic [7:0]  wr_d;
    logic [7:0]  bus_q;
    logic [7:0]  rd;
    logic [12:0] last_a;
    logic        busy;
    logic        drv;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        busy = 1'b0;
        last_a = '0;
        last_d = '0;
        bus_q = '0;
    end
    // data taken from the resolved bus, so a host that floats it is caught
    always @(negedge we_n) wr_d = dq_i; // one byte per write cycle
    always @(posedge we_n) begin
        if (!ce_n && oe_n && !oe_hv && !busy) begin
            mem[addr] = wr_d;
            last_a = addr;
            last_d = wr_d;
            busy = 1'b1;
            #(WR_NS) busy = 1'b0;
        end
    end
    always @(posedge oe_hv) begin
        #1;
        if (!ce_n && we_hv) begin
            foreach (mem[i]) mem[i] = 8'hff;
        end else if (!ce_n && we_n && dq_oe && dq_i === 8'hff) begin
            foreach (mem[i]) mem[i] = 8'hff;
        end
    end
    // ==========================================================
    // pins: released lines show a changing pattern, never the last value
    assign drv = !ce_n && !oe_n && we_n && !oe_hv && !we_hv;
    always @* begin
        rd = mem[addr];
        if (busy && addr == last_a) begin
            rd = {~last_d[7], ~bus_q[6:0]};
        end
    end
    assign dq_i = dq_oe ? dq_o : (drv ? rd : ~bus_q);
    always @(posedge clk) bus_q <= dq_i;
    assign rdy_busy = busy ? 1'b0 : 1'b1;
endmodule // eec_mem_model
`default_nettype wire

// [testbench/tb.sv]
// tb: self-checking bench for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
module tb
    import eec_pkg::*;
;
    // ==========================================================
    // signals and instances
    localparam logic [19:0] REC = 20'h00032;
    localparam logic [19:0] ERS = 20'h00028;
    logic        clk, rstn, req, ready, done, ce_n, oe_n, we_n;
    logic        oe_hv, we_hv, dq_oe, rdy;
    logic [1:0]  cmd;
    logic [12:0] addr, mem_addr;
    logic [7:0]  wdata, rdata, dq_o, dq_i;
    int          failures, n_checks, n_done, we_cnt, rdy_cnt;
    bit          wr_seen, oe_n_prev;
    eec_host #(.WR_RECOVERY_CYC(REC), .ERASE_CYC(ERS), .USE_RDY_PIN(1'b0)) DUT (
        .clk(clk), .rstn(rstn), .req(req), .cmd(cmd), .addr(addr),
        .wdata(wdata), .ready(ready), .done(done), .rdata(rdata),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .oe_hv(oe_hv), .we_hv(we_hv),
        .mem_addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
        .rdy_busy_i(rdy));
    eec_mem_model #(.WR_NS(3000)) u_mem (
        .clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .oe_hv(oe_hv),
        .we_hv(we_hv), .addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe),
        .dq_i(dq_i), .rdy_busy(rdy));
    initial clk = 1'b0;
    always #10 clk = ~clk;
    // ==========================================================
    // compare and bus tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    // poke raises a second request mid-write, which must be ignored
    task automatic run(input logic [1:0] c, input logic [12:0] a,
                       input logic [7:0] d, input bit poke);
        int i;
        @(negedge clk);
        req = 1'b1;
        cmd = c;
        addr = a;
        wdata = d;
        @(negedge clk);
        req = 1'b0;
        chk1(ready, 1'b0);
        if (poke) begin
            repeat (5) @(negedge clk);
            req = 1'b1;
            addr = a ^ 13'h0001;
            wdata = 8'h00;
            repeat (3) @(negedge clk);
            chk1(ready, 1'b0);
            req = 1'b0;
        end
        for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
        chk1(done, 1'b1);
        chk1(ready, 1'b1);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        run(EEC_CMD_READ, a, 8'h00, 1'b0);
        chk8(rdata, exp);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk1(ce_n, 1'b1);
        chk1(dq_oe, 1'b0);
        chk1(rdy, 1'b1);
        rd_chk(13'h0000, 8'hff);
        $display("test reset done");
    endtask
    task automatic t_write;
        logic [12:0] at [3] = '{13'h1abc, 13'h0001, 13'h1abc};
        logic [7:0]  dt [3] = '{8'h5a, 8'ha5, 8'h80};
        for (int i = 0; i < 3; i++) begin
            run(EEC_CMD_WRITE, at[i], dt[i], 1'b0);
            chk1(rdy_cnt >= int'(REC), 1'b1);
            chk1(ce_n, 1'b1);
            rd_chk(at[i], dt[i]);
        end
        $display("test write done");
    endtask
    task automatic t_refuse;
        int n0;
        // let the pulse of the last read be counted before taking the base
        @(negedge clk);
        n0 = n_done;
        run(EEC_CMD_WRITE, 13'h0100, 8'h3c, 1'b1);
        repeat (3) @(negedge clk);
        chk1(n_done == n0 + 1, 1'b1);
        rd_chk(13'h0101, 8'hff);
        rd_chk(13'h0100, 8'h3c);
        $display("test refuse done");
    endtask
    task automatic t_erase;
        run(EEC_CMD_ERASE, 13'h0000, 8'h00, 1'b0);
        rd_chk(13'h1abc, 8'hff);
        rd_chk(13'h0100, 8'hff);
        run(EEC_CMD_WRITE, 13'h0020, 8'h11, 1'b0);
        rd_chk(13'h0020, 8'h11);
        run(EEC_CMD_CLEAR, 13'h0000, 8'h00, 1'b0);
        rd_chk(13'h0020, 8'hff);
        $display("test erase and clear done");
    endtask
    // ==========================================================
    // pin monitors
    // sampled on the falling edge, away from the edge that launches the pins
    always @(negedge clk) begin
        rdy_cnt <= rdy ? rdy_cnt + 1 : 0;
        we_cnt <= we_n ? we_cnt + 1 : 0;
        oe_n_prev <= oe_n;
        if (done === 1'b1) n_done++;
        if (rstn) begin
            if (!we_n) wr_seen <= 1'b1;
            if (!we_n) chk1(oe_n & !ce_n & dq_oe, 1'b1);
            if (we_hv) chk1(oe_hv & !dq_oe & !ce_n, 1'b1);
            if (oe_hv & !we_hv) chk8(dq_oe ? dq_o : 8'h00, 8'hff);
            if (oe_n_prev && !oe_n && wr_seen) begin
                chk1(we_cnt >= int'(ACC_CYC), 1'b1);
            end
        end
    end
    // ==========================================================
    // sequence, watchdog and verdict
    task automatic report_and_stop;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        req = 1'b0;
        cmd = 2'h0;
        addr = 13'h0000;
        wdata = 8'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_write();
        t_refuse();
        t_erase();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
